// *** include/rmp_pkg.sv ***
package rmp_pkg;

    localparam int CLK_PERIOD_NS = 4;
    localparam int SCL_PERIOD_NS = 1000;
    localparam int QTR_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam int NV_WRITE_TIME_US = 20;
    localparam int NV_WAIT_CYCLES = (NV_WRITE_TIME_US * 1000) / CLK_PERIOD_NS;

    localparam logic [6:0] DEV_ADDR = 7'h50;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;
    localparam int ROW_LSB = 2;
    localparam logic [ROW_LSB-1:0] ROW_FIRST = 2'h0;

    localparam logic [3:0] BC_ACK = 4'h8;
    localparam logic [1:0] PH_FIRST = 2'h0;
    localparam logic [1:0] PH_SAMPLE = 2'h2;
    localparam logic [1:0] PH_LAST = 2'h3;
    localparam logic [31:0] WAIT_RST = 32'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;

    typedef enum logic [1:0] {
        OP_START,
        OP_STOP,
        OP_WRITE,
        OP_READ
    } rmp_bit_op_t;

    typedef enum logic [1:0] {
        CMD_WRITE,
        CMD_READ_CUR,
        CMD_READ_AT
    } rmp_cmd_t;

endpackage

// *** verif/rmp_dev_model.sv ***
module rmp_dev_model
    import rmp_pkg::*;
#(
    parameter int COMMIT_NS = 120000
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic module_select_n,
    input wire logic nack_all,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    typedef enum logic [2:0] {MS_IDLE, MS_ADDR, MS_MADDR, MS_DATA, MS_TX} rmp_ms_t;
    logic [7:0] mem [256];
    logic [7:0] row_buf [4];
    logic [7:0] ptr = 8'h00;
    logic [7:0] sh = 8'h00;
    logic [7:0] txb = 8'h00;
    logic [3:0] cnt = 4'h0;
    logic mack = 1'b1;
    logic dirty = 1'b0;
    logic busy = 1'b0;
    rmp_ms_t st = MS_IDLE;

    initial begin
        sda_pull = 1'b0;
        for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'hA5;
    end

    always @(negedge sda) if (scl) begin
        st = MS_ADDR;
        cnt = 4'h0;
    end

    // The row is copied whole, so untouched bytes keep their old values.
    always @(posedge sda) if (scl) begin
        st = MS_IDLE;
        if (dirty) begin
            for (int i = 0; i < 4; i++) mem[{ptr[7:2], i[1:0]}] = row_buf[i];
            dirty = 1'b0;
            busy = 1'b1;
            busy <= #COMMIT_NS 1'b0;
        end
    end

    always @(posedge scl) if (st != MS_IDLE) begin
        if (cnt < 4'h8) sh = {sh[6:0], sda};
        else mack = sda;
        cnt = cnt + 4'h1;
    end

    // Our own address acknowledge reads back as zero, which loads the first byte.
    always @(negedge scl) if (st != MS_IDLE) begin
        if (cnt == 4'h9) begin
            cnt = 4'h0;
            sda_pull = 1'b0;
            if (st == MS_TX && mack) st = MS_IDLE;
            else if (st == MS_TX) begin
                txb = mem[ptr];
                ptr = ptr + 8'h1;
            end
        end else if (cnt == 4'h8) begin
            sda_pull = 1'b0;
            if (st == MS_ADDR) begin
                if (sh[7:1] == DEV_ADDR && !module_select_n && !busy && !nack_all) begin
                    sda_pull = 1'b1;
                    st = sh[0] ? MS_TX : MS_MADDR;
                end else st = MS_IDLE;
            end else if (st == MS_MADDR) begin
                ptr = sh;
                for (int i = 0; i < 4; i++) row_buf[i] = mem[{sh[7:2], i[1:0]}];
                sda_pull = 1'b1;
                st = MS_DATA;
            end else if (st == MS_DATA) begin
                row_buf[ptr[1:0]] = sh;
                ptr[1:0] = ptr[1:0] + 2'h1;
                dirty = 1'b1;
                sda_pull = 1'b1;
            end
        end
        if (st == MS_TX && cnt < 4'h8) sda_pull = !txb[7 - cnt];
    end
endmodule

// *** verif/rmp_host_assertions.sv ***
module rmp_host_checker (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic busy,
    input wire logic done,
    input wire logic fail,
    input wire logic rd_valid,
    input wire logic rd_last,
    input wire logic module_select_n,
    input wire logic scl_oe,
    input wire logic sda_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_start_then_clock: assert property (
        $rose(sda_oe) && !scl_oe |-> !scl_oe [*8] ##[1:700] scl_oe)
        else $error("start not followed by a clock low");
    a_stop_bus_idle: assert property (
        $fell(sda_oe) && !scl_oe |-> (!sda_oe && !scl_oe) [*8])
        else $error("bus not idle after stop");
    a_select_on_accept: assert property (
        cmd_valid && cmd_ready |=> !module_select_n && busy)
        else $error("select not low after accept");
    a_select_while_bus: assert property (
        scl_oe || sda_oe |-> !module_select_n)
        else $error("bus driven without select");
    a_scl_low_min: assert property ($rose(scl_oe) |-> scl_oe [*8])
        else $error("clock low phase too short");
    a_sda_hold_high: assert property ($fell(scl_oe) |-> $stable(sda_oe) [*8])
        else $error("data moved while clock high");
    a_rd_byte_gap: assert property (rd_valid |=> !rd_valid [*8])
        else $error("read bytes too close");
    a_done_bus_idle: assert property (
        done |-> !$past(scl_oe) && !$past(sda_oe) && module_select_n)
        else $error("done before bus released");

    c_last_read: cover property (rd_valid && rd_last);
    c_failed: cover property ($rose(fail));
    c_clean_done: cover property (done && !fail);
endmodule

// *** verif/tb_rmp_host.sv ***
module tb_rmp_host
    import rmp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    rmp_cmd_t cmd_kind = CMD_WRITE;
    logic [7:0] cmd_addr = 8'h00;
    logic [7:0] cmd_len = 8'h01;
    logic wr_valid = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic nack_all = 1'b0;
    logic cmd_ready, wr_ready, rd_valid, rd_last, done, fail, busy, module_select_n;
    logic scl_o, scl_oe, sda_o, sda_oe, slv_pull;
    logic [7:0] rd_data;
    wire logic scl_w = !scl_oe;
    wire logic sda_w = !(sda_oe | slv_pull);
    int failures = 0;
    int samples_checked = 0;
    int wi = 0;
    logic [7:0] wd [4];
    logic [7:0] exp_mem [256];
    logic [7:0] rq [$];
    logic rl [$];
    logic [7:0] a;
    logic take = 1'b0;

    always #2 ref_clk = !ref_clk;

    rmp_host #(.LEN_W(8), .NV_WAIT(100000)) uut (
        .ref_clk(ref_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
        .rd_last(rd_last), .done(done), .fail(fail), .busy(busy),
        .module_select_n(module_select_n), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe(sda_oe));

    rmp_dev_model #(.COMMIT_NS(20000)) dev (.scl(scl_w), .sda(sda_w),
        .module_select_n(module_select_n),
        .nack_all(nack_all), .sda_pull(slv_pull));

    // Handshakes are judged at the falling edge, where the design's outputs have settled.
    always @(negedge ref_clk) begin
        take <= wr_valid && wr_ready;
    end

    always @(posedge ref_clk) begin
        if (take) begin
            wi <= wi + 1;
            wr_data <= wd[(wi + 1) & 3];
        end
    end

    always @(negedge ref_clk) begin
        if (rd_valid) begin
            rq.push_back(rd_data);
            rl.push_back(rd_last);
        end
    end

    task automatic wrap_up();
        if (failures == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_flag(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    task automatic run_cmd(input rmp_cmd_t k, input logic [7:0] ad, input logic [7:0] n);
        int t;
        t = 0;
        wi = 0;
        rq.delete();
        rl.delete();
        cmd_kind <= k;
        cmd_addr <= ad;
        cmd_len <= n;
        wr_data <= wd[0];
        wr_valid <= (k == CMD_WRITE);
        cmd_valid <= 1'b1;
        @(negedge ref_clk);
        while (cmd_ready !== 1'b1) @(negedge ref_clk);
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        while (done !== 1'b1 && t < 60000) begin
            @(negedge ref_clk);
            t++;
        end
        if (t >= 60000) begin
            failures++;
            wrap_up();
        end
        @(posedge ref_clk);
        wr_valid <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic check_read(input logic [7:0] ad, input int n);
        cmp_flag("fail", 1'b0, fail);
        cmp_byte("count", n[7:0], 8'(rq.size()));
        for (int i = 0; i < n; i++) begin
            cmp_byte("rd_data", exp_mem[8'(ad + i)], rq[i]);
            cmp_flag("rd_last", i == n - 1, rl[i]);
        end
    endtask

    initial begin
        void'($urandom(32'h18C7DA83));
        for (int i = 0; i < 256; i++) exp_mem[i] = i[7:0] ^ 8'hA5;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        // Start on the last byte of a random row so the write must cross rows.
        a = {6'($urandom), 2'h3};
        wd[0] = 8'($urandom);
        wd[1] = 8'($urandom);
        run_cmd(CMD_WRITE, a, 8'h02);
        cmp_flag("fail", 1'b0, fail);
        exp_mem[a] = wd[0];
        exp_mem[8'(a + 1)] = wd[1];
        run_cmd(CMD_READ_AT, 8'(a - 1), 8'h04);
        check_read(8'(a - 1), 4);
        run_cmd(CMD_READ_CUR, 8'h00, 8'h01);
        check_read(8'(a + 3), 1);
        nack_all <= 1'b1;
        run_cmd(CMD_READ_CUR, 8'h00, 8'h01);
        cmp_flag("fail", 1'b1, fail);
        cmp_byte("count", 8'h00, 8'(rq.size()));
        wrap_up();
    end

    // Four commands with their polls take about 47k cycles; allow well over that.
    initial begin
        #(90000 * 4);
        failures++;
        wrap_up();
    end
endmodule

bind rmp_host rmp_host_checker chk (.ref_clk(ref_clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .busy(busy), .done(done), .fail(fail), .rd_valid(rd_valid),
    .rd_last(rd_last), .module_select_n(module_select_n), .scl_oe(scl_oe), .sda_oe(sda_oe));

// *** verilog/rmp_bit_eng.sv ***
module rmp_bit_eng
    import rmp_pkg::*;
#(
    parameter int QTR = QTR_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic go,
    input rmp_bit_op_t op,
    input wire logic tx_bit,
    output logic ready,
    output logic done,
    output logic rx_bit,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    localparam int CW = $clog2(QTR + 1);
    localparam logic [CW-1:0] CNT_END = CW'(QTR - 1);

    generate
        if (QTR < 4) begin : g_chk
            $error("QTR must cover the SDA synchroniser delay");
        end
    endgenerate

    logic sy1_r, sy2_r, sy3_r, sda_f_r, sda_f_nxt;
    logic busy_r, busy_nxt, tx_r, tx_nxt, rx_r, rx_nxt, done_r, done_nxt;
    logic scl_low_r, scl_low_nxt, sda_low_r, sda_low_nxt;
    rmp_bit_op_t op_r, op_nxt;
    logic [1:0] ph_r, ph_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;

    // Pin levels {scl_low, sda_low} for each quarter of a bit slot.
    function automatic logic [1:0] drv(rmp_bit_op_t o, logic [1:0] p, logic t, logic cur);
        logic [1:0] r;
        r = 2'h0;
        case (o)
            OP_START: r = {p == 2'h0 || p == 2'h3, p[1]};
            OP_STOP: r = {p == 2'h0, ~p[1]};
            OP_WRITE: r = (p == 2'h0) ? {1'b1, cur} : {~p[1], ~t};
            OP_READ: r = (p == 2'h0) ? {1'b1, cur} : {~p[1], 1'b0};
            default: r = 2'h0;
        endcase
        return r;
    endfunction

    // A change on SDA counts only once the second and third stages agree.
    always_comb sda_f_nxt = (sy2_r == sy3_r) ? sy2_r : sda_f_r;

    always_comb begin
        busy_nxt = busy_r;
        op_nxt = op_r;
        ph_nxt = ph_r;
        cnt_nxt = cnt_r;
        tx_nxt = tx_r;
        rx_nxt = rx_r;
        done_nxt = 1'b0;
        {scl_low_nxt, sda_low_nxt} = {scl_low_r, sda_low_r};
        if (!busy_r) begin
            if (go) begin
                busy_nxt = 1'b1;
                op_nxt = op;
                tx_nxt = tx_bit;
                ph_nxt = PH_FIRST;
                cnt_nxt = '0;
                {scl_low_nxt, sda_low_nxt} = drv(op, PH_FIRST, tx_bit, sda_low_r);
            end
        end else if (cnt_r == CNT_END) begin
            cnt_nxt = '0;
            if (ph_r == PH_SAMPLE) begin
                rx_nxt = sda_f_r;
            end
            if (ph_r == PH_LAST) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end else begin
                ph_nxt = ph_r + 2'h1;
                {scl_low_nxt, sda_low_nxt} = drv(op_r, ph_r + 2'h1, tx_r, sda_low_r);
            end
        end else begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sy1_r <= 1'b1;
            sy2_r <= 1'b1;
            sy3_r <= 1'b1;
            sda_f_r <= 1'b1;
            busy_r <= 1'b0;
            op_r <= OP_STOP;
            ph_r <= PH_FIRST;
            cnt_r <= '0;
            tx_r <= 1'b1;
            rx_r <= 1'b1;
            done_r <= 1'b0;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
        end else begin
            sy1_r <= sda_i;
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
            sda_f_r <= sda_f_nxt;
            busy_r <= busy_nxt;
            op_r <= op_nxt;
            ph_r <= ph_nxt;
            cnt_r <= cnt_nxt;
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
            done_r <= done_nxt;
            scl_low_r <= scl_low_nxt;
            sda_low_r <= sda_low_nxt;
        end
    end

    assign ready = !busy_r;
    assign done = done_r;
    assign rx_bit = rx_r;
    assign scl_o = 1'b0;
    assign scl_oe = scl_low_r;
    assign sda_o = 1'b0;
    assign sda_oe = sda_low_r;

endmodule

// *** verilog/rmp_host.sv ***
module rmp_host
    import rmp_pkg::*;
#(
    parameter int LEN_W = 8,
    parameter int NV_WAIT = NV_WAIT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input rmp_cmd_t cmd_kind,
    input wire logic [7:0] cmd_addr,
    input wire logic [LEN_W-1:0] cmd_len,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [7:0] wr_data,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic rd_last,
    output logic done,
    output logic fail,
    output logic busy,
    output logic module_select_n,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    localparam logic [LEN_W-1:0] LEN_ONE = LEN_W'(1);

    generate
        if (LEN_W < 1 || LEN_W > 16 || NV_WAIT < 1) begin : g_chk
            $error("rmp_host parameters out of range");
        end
    endgenerate

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_SEND,
        ST_LOAD,
        ST_RECV,
        ST_STOP,
        ST_FIN
    } rmp_state_t;

    typedef enum logic [2:0] {
        STEP_DEVW,
        STEP_MEM,
        STEP_WDATA,
        STEP_DEVR,
        STEP_RDATA
    } rmp_step_t;

    rmp_state_t st_r, st_nxt;
    rmp_step_t step_r, step_nxt;
    rmp_cmd_t kind_r, kind_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [LEN_W-1:0] rem_r, rem_nxt;
    logic [3:0] bc_r, bc_nxt;
    logic [31:0] wait_r, wait_nxt;
    logic issued_r, issued_nxt;
    logic polling_r, polling_nxt;
    logic fail_r, fail_nxt;
    logic done_r, done_nxt;
    logic rdv_r, rdv_nxt;
    logic rdl_r, rdl_nxt;
    logic [7:0] rdd_r, rdd_nxt;
    logic sel_n_r, sel_n_nxt;

    logic eng_go, eng_tx, eng_ready, eng_done, eng_rx, ack;
    rmp_bit_op_t eng_op;
    logic [7:0] addr_inc;

    rmp_bit_eng #(
        .QTR(QTR_CYCLES)
    ) u_bit (
        .ref_clk(ref_clk),
        .reset(reset),
        .go(eng_go),
        .op(eng_op),
        .tx_bit(eng_tx),
        .ready(eng_ready),
        .done(eng_done),
        .rx_bit(eng_rx),
        .scl_o(scl_o),
        .scl_oe(scl_oe),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe(sda_oe)
    );

    // One bit-level operation is in flight at a time; issued_r blocks a second
    // issue until the engine reports completion.
    always_comb begin
        eng_go = 1'b0;
        eng_op = OP_STOP;
        eng_tx = 1'b1;
        case (st_r)
            ST_START: begin
                eng_go = !issued_r;
                eng_op = OP_START;
            end
            ST_SEND: begin
                eng_go = !issued_r;
                eng_op = (bc_r == BC_ACK) ? OP_READ : OP_WRITE;
                eng_tx = sh_r[7];
            end
            ST_RECV: begin
                eng_go = !issued_r;
                eng_op = (bc_r == BC_ACK) ? OP_WRITE : OP_READ;
                eng_tx = (rem_r == LEN_ONE);
            end
            ST_STOP: begin
                eng_go = !issued_r;
                eng_op = OP_STOP;
            end
            default: begin
                eng_go = 1'b0;
            end
        endcase
    end

    assign ack = !eng_rx;
    assign addr_inc = addr_r + 8'h01;

    always_comb begin
        st_nxt = st_r;
        step_nxt = step_r;
        kind_nxt = kind_r;
        addr_nxt = addr_r;
        sh_nxt = sh_r;
        rem_nxt = rem_r;
        bc_nxt = bc_r;
        polling_nxt = polling_r;
        fail_nxt = fail_r;
        done_nxt = 1'b0;
        rdv_nxt = 1'b0;
        rdl_nxt = rdl_r;
        rdd_nxt = rdd_r;
        issued_nxt = issued_r;
        wait_nxt = wait_r;
        if (eng_go && eng_ready) begin
            issued_nxt = 1'b1;
        end else if (eng_done) begin
            issued_nxt = 1'b0;
        end
        // The commit window is timed from the acknowledge of the row's last data byte, before its STOP.
        if (polling_r && wait_r != WAIT_RST) begin
            wait_nxt = wait_r - 32'h1;
        end
        case (st_r)
            ST_IDLE: begin
                if (cmd_valid) begin
                    kind_nxt = cmd_kind;
                    addr_nxt = cmd_addr;
                    rem_nxt = (cmd_len == '0) ? LEN_ONE : cmd_len;
                    fail_nxt = 1'b0;
                    polling_nxt = 1'b0;
                    // A current-address read skips the address byte.
                    step_nxt = (cmd_kind == CMD_READ_CUR) ? STEP_DEVR : STEP_DEVW;
                    st_nxt = ST_START;
                end
            end
            ST_START: begin
                if (eng_done) begin
                    sh_nxt = {DEV_ADDR, (step_r == STEP_DEVR) ? RW_READ : RW_WRITE};
                    bc_nxt = 4'h0;
                    st_nxt = ST_SEND;
                end
            end
            ST_SEND: begin
                if (eng_done && bc_r != BC_ACK) begin
                    sh_nxt = {sh_r[6:0], 1'b0};
                    bc_nxt = bc_r + 4'h1;
                end else if (eng_done) begin
                    bc_nxt = 4'h0;
                    st_nxt = ST_STOP;
                    case (step_r)
                        STEP_DEVW: begin
                            if (!ack) begin
                                // A busy slave NACKs until its row is committed.
                                if (!polling_r || wait_r == WAIT_RST) begin
                                    fail_nxt = 1'b1;
                                    polling_nxt = 1'b0;
                                end
                            end else begin
                                polling_nxt = 1'b0;
                                if (!(kind_r == CMD_WRITE && rem_r == '0)) begin
                                    step_nxt = STEP_MEM;
                                    sh_nxt = addr_r;
                                    st_nxt = ST_SEND;
                                end
                            end
                        end
                        STEP_MEM: begin
                            if (!ack) begin
                                fail_nxt = 1'b1;
                            end else if (kind_r == CMD_WRITE) begin
                                step_nxt = STEP_WDATA;
                                st_nxt = ST_LOAD;
                            end else begin
                                step_nxt = STEP_DEVR;
                                st_nxt = ST_START;
                            end
                        end
                        STEP_DEVR: begin
                            if (!ack) begin
                                fail_nxt = 1'b1;
                            end else begin
                                step_nxt = STEP_RDATA;
                                st_nxt = ST_RECV;
                            end
                        end
                        STEP_WDATA: begin
                            if (!ack) begin
                                fail_nxt = 1'b1;
                            end else begin
                                addr_nxt = addr_inc;
                                rem_nxt = rem_r - LEN_ONE;
                                // Stop at the row end so the slave never wraps.
                                if (rem_r == LEN_ONE || addr_inc[ROW_LSB-1:0] == ROW_FIRST) begin
                                    polling_nxt = 1'b1;
                                    wait_nxt = 32'(NV_WAIT);
                                end else begin
                                    st_nxt = ST_LOAD;
                                end
                            end
                        end
                        default: begin
                            fail_nxt = 1'b1;
                        end
                    endcase
                end
            end
            ST_LOAD: begin
                if (wr_valid) begin
                    sh_nxt = wr_data;
                    bc_nxt = 4'h0;
                    st_nxt = ST_SEND;
                end
            end
            ST_RECV: begin
                if (eng_done && bc_r != BC_ACK) begin
                    sh_nxt = {sh_r[6:0], eng_rx};
                    bc_nxt = bc_r + 4'h1;
                end else if (eng_done) begin
                    rdv_nxt = 1'b1;
                    rdd_nxt = sh_r;
                    rdl_nxt = (rem_r == LEN_ONE);
                    bc_nxt = 4'h0;
                    // The slave steps and loops its own counter between bytes.
                    if (rem_r == LEN_ONE) begin
                        st_nxt = ST_STOP;
                    end else begin
                        rem_nxt = rem_r - LEN_ONE;
                    end
                end
            end
            ST_STOP: begin
                if (eng_done) begin
                    // Readdressing during the commit is the acknowledge poll.
                    st_nxt = polling_r ? ST_START : ST_FIN;
                    step_nxt = STEP_DEVW;
                end
            end
            ST_FIN: begin
                done_nxt = 1'b1;
                st_nxt = ST_IDLE;
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
        sel_n_nxt = (st_nxt == ST_IDLE);
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_r <= ST_IDLE;
            step_r <= STEP_DEVW;
            kind_r <= CMD_WRITE;
            addr_r <= BYTE_RST;
            sh_r <= BYTE_RST;
            rem_r <= '0;
            bc_r <= 4'h0;
            wait_r <= WAIT_RST;
            issued_r <= 1'b0;
            polling_r <= 1'b0;
            fail_r <= 1'b0;
            done_r <= 1'b0;
            rdv_r <= 1'b0;
            rdl_r <= 1'b0;
            rdd_r <= BYTE_RST;
            sel_n_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            step_r <= step_nxt;
            kind_r <= kind_nxt;
            addr_r <= addr_nxt;
            sh_r <= sh_nxt;
            rem_r <= rem_nxt;
            bc_r <= bc_nxt;
            wait_r <= wait_nxt;
            issued_r <= issued_nxt;
            polling_r <= polling_nxt;
            fail_r <= fail_nxt;
            done_r <= done_nxt;
            rdv_r <= rdv_nxt;
            rdl_r <= rdl_nxt;
            rdd_r <= rdd_nxt;
            sel_n_r <= sel_n_nxt;
        end
    end

    // Clock stretching is not honoured: SCL is driven open-drain from the
    // divider and its level is never read back.
    assign cmd_ready = (st_r == ST_IDLE);
    assign wr_ready = (st_r == ST_LOAD);
    assign busy = (st_r != ST_IDLE);
    assign rd_valid = rdv_r;
    assign rd_data = rdd_r;
    assign rd_last = rdl_r;
    assign done = done_r;
    assign fail = fail_r;
    assign module_select_n = sel_n_r;

endmodule
